// ===== dram_mode_regs.vh
// Constants for the mode-register decode and latency block.
// Assumes inclusion by the single design file only.
`ifndef DRAM_MODE_REGS_VH
`define DRAM_MODE_REGS_VH

// Register byte offsets on the control bus
`define OFS_CTRL 12'h000
`define OFS_FIRST_MODE 12'h004
`define OFS_SECOND_MODE 12'h008
`define OFS_THIRD_MODE 12'h00c
`define OFS_STATUS 12'h010

// Control register fields and reset values
`define CTRL_CAS_LSB 0
`define CTRL_CAS_MSB 4
`define CTRL_SELF_REFRESH_BIT 8
`define CTRL_CAS_RESET 5'h06

// Mode register select on bank address
`define BANK_FIRST_MODE 3'h1
`define BANK_SECOND_MODE 3'h2
`define BANK_THIRD_MODE 3'h3

// First mode register fields
`define FIRST_ADD_LAT_LSB 3
`define FIRST_ADD_LAT_MSB 4
`define FIRST_WRITE_LEVEL_BIT 7
`define FIRST_NOM_TERM_B0 2
`define FIRST_NOM_TERM_B1 6
`define FIRST_NOM_TERM_B2 9
`define ADD_LAT_ZERO 2'h0
`define ADD_LAT_CAS_LESS_ONE 2'h1
`define ADD_LAT_CAS_LESS_TWO 2'h2

// Second mode register fields
`define SECOND_WR_CAS_LSB 3
`define SECOND_WR_CAS_MSB 5
`define SECOND_AUTO_SR_BIT 6
`define SECOND_EXT_TEMP_BIT 7
`define SECOND_WR_TERM_LSB 9
`define SECOND_WR_TERM_MSB 10
`define WR_CAS_BASE 6'h05

// Third mode register fields
`define THIRD_PATTERN_SEL_LSB 0
`define THIRD_PATTERN_SEL_MSB 1
`define THIRD_PATTERN_EN_BIT 2
`define PATTERN_SEL_CAL 2'h0
`define CAL_PATTERN 8'haa

// Timing count and mode-register reset value
`define WRITE_BURST_CLKS 3'h4
`define MODE_RESET 18'h00000

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== dram_mode_register_latency_refresh_odt.v
// Mode-register decode, posted latency timing, self-refresh rate and
// dynamic termination control of a DDR3 memory device.
// Assumes commands arrive already decoded on i_mclk; a temperature
// flag arrives from an asynchronous sensor pin.
`timescale 1ns/1ps
`default_nettype none
`include "dram_mode_regs.vh"

// Contract
// - First register bits 4:3 pick additive latency zero, read latency less one or two.
// - Accepted read or write waits additive latency before internal release.
// - Read data appear after additive latency plus read CAS latency.
// - Write data expected after additive latency plus write CAS latency.
// - Second and third registers keep contents until reprogrammed; array untouched.
// - Write CAS latency comes from second register bits 5:3.
// - Auto self refresh doubles refresh rate when case runs hot.
// - Neither auto nor extended mode: self refresh at single rate.
// - Extended-temperature bit forces double self-refresh rate always.
// - Auto mode may switch to double rate early, never losing data.
// - Nonzero second-register bits 10:9 enable dynamic write termination.
// - Write termination applies during write burst, nominal restored after.
// - Nominal and write termination independent; nominal off means high impedance.
// - Write termination only during writes, never while write leveling.
// - Pattern-select bits ignored while pattern access is off.
// - Third register bit 2 redirects reads to calibration pattern 10101010; code outputs it only with select bits 1:0 at 00, else 00000000.
module dram_mode_register_latency_refresh_odt #(
  parameter PIPE_DEPTH = 64,
  parameter REFRESH_INTERVAL = 390
)(
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_cmd_valid,
  input wire i_cmd_mode_set,
  input wire i_cmd_read,
  input wire i_cmd_write,
  input wire [2:0] i_bank,
  input wire [17:0] i_addr,
  input wire i_temp_hot,
  input wire [11:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [11:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output reg o_read_release,
  output reg o_write_release,
  output reg o_read_data_valid,
  output reg o_read_from_pattern,
  output reg o_write_data_latch,
  output reg [7:0] o_pattern_data,
  output reg o_write_term_active,
  output reg [1:0] o_write_term_code,
  output reg [2:0] o_nominal_term_code,
  output reg o_refresh_2x,
  output reg o_refresh_pulse
);

  reg [17:0] first_mode_reg;
  reg [17:0] second_mode_reg;
  reg [17:0] third_mode_reg;
  reg [4:0] cas_reg;
  reg self_refresh_reg;
  reg [PIPE_DEPTH-1:0] rd_pipe_reg;
  reg [PIPE_DEPTH-1:0] wr_pipe_reg;
  reg [2:0] burst_cnt_reg;
  reg [2:0] temp_sync_reg;
  reg hot_reg;
  reg [15:0] refresh_cnt_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg [11:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire mode_cmd = i_cmd_valid & i_cmd_mode_set;
  wire rd_cmd = i_cmd_valid & i_cmd_read & ~i_cmd_mode_set;
  wire wr_cmd = i_cmd_valid & i_cmd_write & ~i_cmd_mode_set;

  // Latency decode
  reg [5:0] additive_latency;
  wire [5:0] read_cas_latency = {1'b0, cas_reg};
  wire [5:0] write_cas_latency;
  wire [5:0] total_read_latency;
  wire [5:0] total_write_latency;

  always @*
  begin
    case (first_mode_reg[`FIRST_ADD_LAT_MSB:`FIRST_ADD_LAT_LSB])
      `ADD_LAT_ZERO: additive_latency = 6'h00;
      `ADD_LAT_CAS_LESS_ONE: additive_latency = read_cas_latency - 6'h01;
      `ADD_LAT_CAS_LESS_TWO: additive_latency = read_cas_latency - 6'h02;
      default: additive_latency = 6'h00;
    endcase
  end

  // Write CAS latency field counts up from the lowest supported value
  assign write_cas_latency = `WR_CAS_BASE +
    {3'h0, second_mode_reg[`SECOND_WR_CAS_MSB:`SECOND_WR_CAS_LSB]};
  assign total_read_latency = additive_latency + read_cas_latency;
  assign total_write_latency = additive_latency + write_cas_latency;

  // Tap k: event k cycles after the command, zero meaning the command cycle
  function tap;
    input [PIPE_DEPTH-1:0] pipe;
    input now;
    input [5:0] k;
    begin
      if (k == 6'h00)
        tap = now;
      else
        tap = pipe[k - 6'h01];
    end
  endfunction

  wire auto_self_refresh = second_mode_reg[`SECOND_AUTO_SR_BIT];
  wire self_refresh_extended_temp = second_mode_reg[`SECOND_EXT_TEMP_BIT];
  wire [1:0] write_termination = second_mode_reg[`SECOND_WR_TERM_MSB:`SECOND_WR_TERM_LSB];
  wire write_leveling = first_mode_reg[`FIRST_WRITE_LEVEL_BIT];
  wire pattern_enable = third_mode_reg[`THIRD_PATTERN_EN_BIT];
  wire [1:0] pattern_sel = third_mode_reg[`THIRD_PATTERN_SEL_MSB:`THIRD_PATTERN_SEL_LSB];
  wire write_data_start = tap(wr_pipe_reg, wr_cmd, total_write_latency);
  // Sensor trips early in auto mode, so switching below threshold is safe
  wire rate_2x = self_refresh_extended_temp | (auto_self_refresh & hot_reg);
  wire [15:0] refresh_period = rate_2x ? REFRESH_INTERVAL[16:1] : REFRESH_INTERVAL[15:0];

  // Mode registers, cleared only by reset
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      first_mode_reg <= `MODE_RESET;
      second_mode_reg <= `MODE_RESET;
      third_mode_reg <= `MODE_RESET;
    end
    else if (mode_cmd)
    begin
      case (i_bank)
        `BANK_FIRST_MODE: first_mode_reg <= i_addr;
        `BANK_SECOND_MODE: second_mode_reg <= i_addr;
        `BANK_THIRD_MODE: third_mode_reg <= i_addr;
        default: first_mode_reg <= first_mode_reg;
      endcase
    end
  end

  // Command delay lines
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      rd_pipe_reg <= {PIPE_DEPTH{1'b0}};
      wr_pipe_reg <= {PIPE_DEPTH{1'b0}};
      o_read_release <= 1'b0;
      o_write_release <= 1'b0;
      o_read_data_valid <= 1'b0;
      o_read_from_pattern <= 1'b0;
      o_write_data_latch <= 1'b0;
      o_pattern_data <= 8'h00;
    end
    else
    begin
      rd_pipe_reg <= {rd_pipe_reg[PIPE_DEPTH-2:0], rd_cmd};
      wr_pipe_reg <= {wr_pipe_reg[PIPE_DEPTH-2:0], wr_cmd};
      o_read_release <= tap(rd_pipe_reg, rd_cmd, additive_latency);
      o_write_release <= tap(wr_pipe_reg, wr_cmd, additive_latency);
      o_read_data_valid <= tap(rd_pipe_reg, rd_cmd, total_read_latency);
      o_read_from_pattern <= pattern_enable &
        tap(rd_pipe_reg, rd_cmd, total_read_latency);
      o_write_data_latch <= write_data_start;
      // Select bits only matter with pattern access on
      if (pattern_enable && pattern_sel == `PATTERN_SEL_CAL)
        o_pattern_data <= `CAL_PATTERN;
      else
        o_pattern_data <= 8'h00;
    end
  end

  // Termination control
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      burst_cnt_reg <= 3'h0;
      o_write_term_active <= 1'b0;
      o_write_term_code <= 2'h0;
      o_nominal_term_code <= 3'h0;
    end
    else
    begin
      if (write_data_start)
        burst_cnt_reg <= `WRITE_BURST_CLKS;
      else if (burst_cnt_reg != 3'h0)
        burst_cnt_reg <= burst_cnt_reg - 3'h1;
      o_write_term_active <= (write_termination != 2'h0) & ~write_leveling &
        (write_data_start | (burst_cnt_reg > 3'h1));
      o_write_term_code <= write_termination;
      // Code zero means nominal termination off, pins left high impedance
      o_nominal_term_code <= {first_mode_reg[`FIRST_NOM_TERM_B2],
        first_mode_reg[`FIRST_NOM_TERM_B1], first_mode_reg[`FIRST_NOM_TERM_B0]};
    end
  end

  // Temperature flag: three stages, change taken once the last two agree
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      temp_sync_reg <= 3'h0;
      hot_reg <= 1'b0;
    end
    else
    begin
      temp_sync_reg <= {temp_sync_reg[1:0], i_temp_hot};
      if (temp_sync_reg[1] == temp_sync_reg[2])
        hot_reg <= temp_sync_reg[2];
    end
  end

  // Self-refresh pacing; period halves at the doubled rate
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      refresh_cnt_reg <= 16'h0000;
      o_refresh_pulse <= 1'b0;
      o_refresh_2x <= 1'b0;
    end
    else
    begin
      o_refresh_2x <= rate_2x;
      if (!self_refresh_reg)
      begin
        refresh_cnt_reg <= 16'h0000;
        o_refresh_pulse <= 1'b0;
      end
      else if (refresh_cnt_reg + 16'h0001 >= refresh_period)
      begin
        refresh_cnt_reg <= 16'h0000;
        o_refresh_pulse <= 1'b1;
      end
      else
      begin
        refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
        o_refresh_pulse <= 1'b0;
      end
    end
  end

  // Control bus slave: address and data taken in either order
  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire aw_now = aw_have_reg | aw_take;
  wire w_now = w_have_reg | w_take;
  wire [11:0] wr_addr = aw_have_reg ? aw_addr_reg : i_awaddr;
  wire [31:0] wr_data = w_have_reg ? w_data_reg : i_wdata;
  wire [3:0] wr_strb = w_have_reg ? w_strb_reg : i_wstrb;
  wire do_write = aw_now & w_now & ~o_bvalid;
  reg [31:0] rd_word;
  reg rd_hit;

  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (i_araddr)
      `OFS_CTRL: rd_word = {23'h0, self_refresh_reg, 3'h0, cas_reg};
      `OFS_FIRST_MODE: rd_word = {14'h0, first_mode_reg};
      `OFS_SECOND_MODE: rd_word = {14'h0, second_mode_reg};
      `OFS_THIRD_MODE: rd_word = {14'h0, third_mode_reg};
      `OFS_STATUS: rd_word = {8'h0, 2'h0, total_write_latency, 2'h0,
        total_read_latency, 5'h0, o_write_term_active, hot_reg, o_refresh_2x};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      cas_reg <= `CTRL_CAS_RESET;
      self_refresh_reg <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_reg <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
        o_wready <= 1'b0;
      end
      aw_have_reg <= aw_now & ~do_write;
      w_have_reg <= w_now & ~do_write;
      if (do_write)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= `RESP_OKAY;
        case (wr_addr)
          `OFS_CTRL:
          begin
            if (wr_strb[0])
              cas_reg <= wr_data[`CTRL_CAS_MSB:`CTRL_CAS_LSB];
            if (wr_strb[1])
              self_refresh_reg <= wr_data[`CTRL_SELF_REFRESH_BIT];
          end
          // Mode shadows and status are read-only; writes are accepted and dropped
          `OFS_FIRST_MODE, `OFS_SECOND_MODE, `OFS_THIRD_MODE, `OFS_STATUS:
            o_bresp <= `RESP_OKAY;
          default: o_bresp <= `RESP_SLVERR;
        endcase
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== mode_regs_chk_sva.sv
// Checker for mode-register decode, termination and refresh-rate outputs.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module mode_regs_chk (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_mode_set,
  input wire logic i_cmd_read,
  input wire logic [2:0] i_bank,
  input wire logic [17:0] i_addr,
  input wire logic o_read_release,
  input wire logic o_read_data_valid,
  input wire logic o_read_from_pattern,
  input wire logic [7:0] o_pattern_data,
  input wire logic o_write_term_active,
  input wire logic [1:0] o_write_term_code,
  input wire logic [2:0] o_nominal_term_code,
  input wire logic o_refresh_2x
);
  logic [17:0] first_reg, second_reg, third_reg;
  logic [1:0] quiet_reg;
  wire settled = quiet_reg == 2'h3;
  // Judge outputs, a_pattern_pulse aside, only once a mode change has had time to land
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      first_reg <= 18'h00000;
      second_reg <= 18'h00000;
      third_reg <= 18'h00000;
      quiet_reg <= 2'h0;
    end
    else if (i_cmd_valid && i_cmd_mode_set)
    begin
      quiet_reg <= 2'h0;
      if (i_bank == 3'h1) first_reg <= i_addr;
      if (i_bank == 3'h2) second_reg <= i_addr;
      if (i_bank == 3'h3) third_reg <= i_addr;
    end
    else if (!settled)
      quiet_reg <= quiet_reg + 2'h1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  a_posted_zero_read: assert property (
    settled && first_reg[4:3] == 2'h0 && i_cmd_valid && !i_cmd_mode_set && i_cmd_read
    |=> o_read_release) else $error("read not released one cycle after command");
  a_pattern_value: assert property (
    settled |-> o_pattern_data == ((third_reg[2] && third_reg[1:0] == 2'h0) ? 8'haa : 8'h00))
    else $error("calibration pattern wrong");
  a_pattern_ignored: assert property (
    settled && !third_reg[2] |-> o_pattern_data == 8'h00 && !o_read_from_pattern)
    else $error("pattern used while access is off");
  a_term_code: assert property (
    settled |-> o_write_term_code == second_reg[10:9]) else $error("write termination code wrong");
  a_nominal_code: assert property (
    settled |-> o_nominal_term_code == {first_reg[9], first_reg[6], first_reg[2]})
    else $error("nominal termination code wrong");
  a_term_gated: assert property (
    settled && (first_reg[7] || second_reg[10:9] == 2'h0) |-> !o_write_term_active)
    else $error("write termination applied while disabled");
  a_srt_double: assert property (
    settled && second_reg[7] |-> o_refresh_2x) else $error("extended mode not at double rate");
  a_single_rate: assert property (
    settled && second_reg[7:6] == 2'h0 |-> !o_refresh_2x)
    else $error("double rate without a mode");
  a_pattern_pulse: assert property (
    o_read_from_pattern |-> o_read_data_valid && third_reg[2])
    else $error("pattern flag misplaced");
  c_pattern_read: cover property (o_read_from_pattern);
  c_term_on: cover property (o_write_term_active);
  c_double_rate: cover property (settled && second_reg[6] && o_refresh_2x);
endmodule
bind dram_mode_register_latency_refresh_odt mode_regs_chk mode_regs_chk_inst (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid),
  .i_cmd_mode_set(i_cmd_mode_set), .i_cmd_read(i_cmd_read), .i_bank(i_bank), .i_addr(i_addr),
  .o_read_release(o_read_release), .o_read_data_valid(o_read_data_valid),
  .o_read_from_pattern(o_read_from_pattern), .o_pattern_data(o_pattern_data),
  .o_write_term_active(o_write_term_active), .o_write_term_code(o_write_term_code),
  .o_nominal_term_code(o_nominal_term_code), .o_refresh_2x(o_refresh_2x));
`default_nettype wire

// ===== mem_ctrl_model.sv
// Memory controller stand-in: mode-register sets and column commands.
// Assumes its tasks are called right after a rising edge of i_mclk.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model #(
  parameter int MODE_WAIT = 12
)(
  input wire logic i_mclk,
  output logic o_cmd_valid,
  output logic o_cmd_mode_set,
  output logic o_cmd_read,
  output logic o_cmd_write,
  output logic [2:0] o_bank,
  output logic [17:0] o_addr
);
  initial
  begin
    o_cmd_valid = 1'h0;
    o_cmd_mode_set = 1'h0;
    o_cmd_read = 1'h0;
    o_cmd_write = 1'h0;
    o_bank = 3'h0;
    o_addr = 18'h00000;
  end
  task automatic mode_set(input logic [2:0] bank, input logic [17:0] val);
    logic [17:0] v;
    v = val;
    if (bank == 3'h2) v = v & 18'h006f8;
    if (bank == 3'h2 && v[7]) v[6] = 1'h0;
    if (bank == 3'h3) v = v & 18'h00007;
    o_cmd_valid <= 1'h1;
    o_cmd_mode_set <= 1'h1;
    o_bank <= bank;
    o_addr <= v;
    @(posedge i_mclk);
    o_cmd_valid <= 1'h0;
    o_cmd_mode_set <= 1'h0;
    // Covers both mode delays; the bank is idle here by construction
    repeat (MODE_WAIT) @(posedge i_mclk);
  endtask
  task automatic column(input logic rd);
    o_cmd_valid <= 1'h1; // Row taken as open long enough for the posted delay
    o_cmd_read <= rd;
    o_cmd_write <= !rd;
    @(posedge i_mclk);
    o_cmd_valid <= 1'h0;
    o_cmd_read <= 1'h0;
    o_cmd_write <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench: latency, pattern, termination and refresh rate.
// Assumes the controller model drives commands and the bench drives the bus.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, reset_n, temp_hot, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, seed, d;
  logic [3:0] wstrb;
  logic [1:0] r;
  wire cv, cms, crd, cwr, awready, wready, bvalid, arready, rvalid, rrel, wrel, rdv, rpat;
  wire wlat, tact, rfp;
  wire [2:0] bank;
  wire [17:0] addr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pdat;
  int n_fail = 0, checks = 0, cyc = 0, rd_cas, lat_code, exp_add, wr_code, tc, pat, gap, t1;
  int lat_q[$];
  dram_mode_register_latency_refresh_odt #(.REFRESH_INTERVAL(8))
    dram_mode_register_latency_refresh_odt_inst (
    .i_mclk(mclk), .i_reset_n(reset_n), .i_cmd_valid(cv), .i_cmd_mode_set(cms),
    .i_cmd_read(crd), .i_cmd_write(cwr), .i_bank(bank), .i_addr(addr), .i_temp_hot(temp_hot),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_read_release(rrel), .o_write_release(wrel), .o_read_data_valid(rdv),
    .o_read_from_pattern(rpat), .o_write_data_latch(wlat), .o_pattern_data(pdat),
    .o_write_term_active(tact), .o_write_term_code(), .o_nominal_term_code(),
    .o_refresh_2x(), .o_refresh_pulse(rfp));
  mem_ctrl_model mem_ctrl_model_inst (.i_mclk(mclk), .o_cmd_valid(cv), .o_cmd_mode_set(cms),
    .o_cmd_read(crd), .o_cmd_write(cwr), .o_bank(bank), .o_addr(addr));
  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A hung handshake lands here instead of spinning forever
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic axi_rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge mclk);
  endtask
  // Edges counted from the command edge to release and to first data
  task automatic measure(input logic rd, input int exp_dat, input logic exp_flag);
    int rel, dat;
    logic flag;
    rel = 0;
    dat = 0;
    mem_ctrl_model_inst.column(rd);
    for (int k = 1; k < 80 && dat == 0; k++)
    begin
      @(posedge mclk);
      if ((rd ? rrel : wrel) && rel == 0) rel = k;
      if (rd ? rdv : wlat) dat = k;
      flag = rd ? rpat : tact;
    end
    check(rel, exp_add + 1);
    if (rd) check(dat, exp_dat);
    if (!rd) check(dat, exp_dat);
    if (rd) check(flag, exp_flag);
    if (!rd) check(flag, exp_flag);
    repeat (4) @(posedge mclk);
    check(tact, 1'h0);
  endtask
  initial
  begin
    {reset_n, temp_hot, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    seed = 32'h120a;
    repeat (3) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    axi_rd(12'h000);
    check(d[4:0], 5'h06);
    axi_rd(12'h020);
    check(r, 2'h2);
    axi_wr(12'h020, 32'h00000000);
    check(r, 2'h2);
    $display("reset and map test done");
    for (int i = 0; i < 8; i++)
    begin
      rd_cas = 5 + rnd() % 7;
      lat_code = i % 4;
      wr_code = rnd() % 4;
      tc = rnd() % 4;
      pat = i % 2;
      exp_add = lat_code == 1 ? rd_cas - 1 : (lat_code == 2 ? rd_cas - 2 : 0);
      lat_q.push_back(exp_add + rd_cas + 1);
      lat_q.push_back(exp_add + 5 + wr_code + 1);
      axi_wr(12'h000, rd_cas);
      check(r, 2'h0);
      mem_ctrl_model_inst.mode_set(3'h1, (lat_code << 3) | (i == 7 ? 18'h00080 : 18'h00004));
      // Any write latency code is taken as matching the bench clock
      mem_ctrl_model_inst.mode_set(3'h2, (wr_code << 3) | (tc << 9));
      // Select bits are random while pattern access is off
      mem_ctrl_model_inst.mode_set(3'h3, pat ? 18'h00004 : rnd() % 4);
      check(pdat, pat ? 8'haa : 8'h00);
      measure(1'h1, lat_q.pop_front(), pat != 0);
      measure(1'h0, lat_q.pop_front(), tc != 0 && i != 7);
      axi_rd(12'h010);
      check(d[21:16], exp_add + 5 + wr_code);
      check(d[13:8], exp_add + rd_cas);
    end
    $display("latency sweep done");
    axi_wr(12'h000, 32'h00000106);
    for (int j = 0; j < 4; j++)
    begin
      temp_hot <= j[0];
      // First hot step runs with auto mode on, second hot step with neither temperature mode
      mem_ctrl_model_inst.mode_set(3'h2, j < 2 ? 18'h00040 : (j == 2 ? 18'h00080 : 18'h0));
      gap = 0;
      t1 = -1;
      for (int k = 0; k < 40 && gap == 0; k++)
      begin
        @(posedge mclk);
        if (rfp && t1 >= 0) gap = k - t1;
        if (rfp) t1 = k;
      end
      check(gap, (j == 1 || j == 2) ? 4 : 8);
      axi_rd(12'h010);
      check(d[1:0], {j[0], j == 1 || j == 2});
    end
    $display("refresh rate test done");
    axi_rd(12'h00c);
    check(d, 32'h00000004);
    reset_n <= 1'h0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    axi_rd(12'h00c);
    check(d, 32'h00000000);
    axi_rd(12'h000);
    check(d[8:0], 9'h006);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
